// ### shared/csl_pkg.sv
// constants, command codes and carrier types for the charger setpoint and safety logic
package csl_pkg;

  // =====================================================================
  // command codes
  localparam logic [7:0] CMD_CURRENT = 8'h14;
  localparam logic [7:0] CMD_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_ALARM = 8'h16;
  localparam logic [7:0] CMD_CONFIG = 8'h12;

  // =====================================================================
  // field layout
  localparam int VCODE_LSB = 4;
  localparam int VCODE_MSB = 14;
  localparam int VCODE_W = VCODE_MSB - VCODE_LSB + 1;
  localparam int VMV_W = 15;
  localparam int ALARM_STOP_LSB = 12;
  localparam int ALARM_STOP_MSB = 15;
  localparam int ALARM_OT_BIT = 12;
  localparam int ALARM_TC_BIT = 14;
  localparam int ALARM_OC_BIT = 15;
  localparam int CFG_HOT_STOP_BIT = 2;
  localparam int CFG_POR_BIT = 3;
  localparam logic CFG_HOT_STOP_RST = 1'b1;

  // =====================================================================
  // voltage limits in millivolts
  localparam logic [VMV_W-1:0] VMIN_MV = 15'h0400;
  localparam logic [VMV_W-1:0] VMAX_MV = 15'h4b00;

  // =====================================================================
  // timing: 1 ms tick from the 40 ns clock, 175 s timeout
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_S = 175;
  localparam int TIMEOUT_TICKS = TIMEOUT_S * 1000;
  localparam int TICK_W = 15;
  localparam int TMO_W = 18;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] data;
  } csl_cmd_s;

  typedef struct packed {
    logic open;
    logic cold;
    logic hot;
    logic shorted;
  } csl_thm_s;

  typedef struct packed {
    logic battery_present;
    logic alarm_block;
    logic shorted;
    logic hot;
    logic cold;
    logic open;
  } csl_status_s;

endpackage

// ### core/csl_sync3.sv
// three-stage synchroniser with agreement filter for one comparator level
`timescale 1ns/100ps
`default_nettype none

module csl_sync3 (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic sync_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } csl_sync_s;

  csl_sync_s st_r;
  csl_sync_s st_nxt;

  // =====================================================================
  // next state: s1 feeds only s2
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.out = st_r.s3;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.out;

  // =====================================================================
  // assertions
  property p_sync_agree;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      $changed(st_r.out) |-> ($past(st_r.s2) == $past(st_r.s3));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("sync output moved without agreement");

endmodule // csl_sync3

`default_nettype wire

// ### core/csl_setpoint_safety.sv
// charger setpoint register, alarm handling, safety timer and thermistor flags
`timescale 1ns/100ps
`default_nettype none

// Operation
// - voltage command bits 4..14 form a binary field, LSB worth 16 mV
// - bits 0..3 and 15 of voltage command are ignored
// - applied charge voltage never below 1024 mV
// - bit 14 worth 16384 mV; applied voltage capped at 19200 mV
// - stop charging after 175 s without voltage or current command
// - each voltage or current command restarts the safety timer
// - alarm bits 12..15 any set stop charging; bits 0..11 ignored
// - temperature status comes from four separate comparator outputs
// - open comparator sets open flag, forces reset state, clears pack present
// - cold flag follows comparator and never affects charging
// - hot flag latches; cleared only by removal or config reset request
// - hot flag stops charging unless halt enable cleared or shorted flag set
// - shorted flag set when sense input is grounded
// - each flag evaluated independently; several may be set together
// - alarm block set by timer expiry or alarm bit 12, 14 or 15
// - alarm block cleared by removal, config reset, or voltage plus current pair
module csl_setpoint_safety #(
  parameter int TICK_CYCLES = csl_pkg::TICK_CYCLES,
  parameter int TIMEOUT_TICKS = csl_pkg::TIMEOUT_TICKS
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire csl_pkg::csl_cmd_s cmd_i,
  input wire csl_pkg::csl_thm_s temp_sense_cmp_i,
  output logic [csl_pkg::VMV_W-1:0] setpoint_mv_o,
  output logic [csl_pkg::VCODE_W-1:0] voltage_code_bits_o,
  output logic charge_enable_o,
  output logic timer_expired_o,
  output csl_pkg::csl_status_s status_o
);

  typedef struct packed {
    logic [csl_pkg::VCODE_W-1:0] vcode;
    logic [csl_pkg::VMV_W-1:0] vset_mv;
    logic vset_valid;
    logic alarm_stop;
    logic alarm_block;
    logic seen_v;
    logic seen_i;
    logic hot_stop_en;
    logic open;
    logic cold;
    logic hot;
    logic shorted;
    logic [csl_pkg::TICK_W-1:0] tick_cnt;
    logic [csl_pkg::TMO_W-1:0] tmo_cnt;
    logic tmo_done;
    logic chg_en;
  } csl_state_s;

  localparam logic [csl_pkg::TICK_W-1:0] TICK_LAST = csl_pkg::TICK_W'(TICK_CYCLES - 1);
  localparam logic [csl_pkg::TMO_W-1:0] TMO_LAST = csl_pkg::TMO_W'(TIMEOUT_TICKS - 1);

  csl_state_s st_r;
  csl_state_s st_nxt;
  csl_pkg::csl_thm_s thm_s;
  logic v_cmd;
  logic i_cmd;
  logic a_cmd;
  logic c_cmd;
  logic por_req;
  logic alarm_set;
  logic restart;
  logic expire;
  logic [csl_pkg::VCODE_W-1:0] new_code;
  logic [csl_pkg::VMV_W-1:0] raw_mv;

  // =====================================================================
  // comparator synchronisers, one per flag
  logic [3:0] cmp_raw;
  logic [3:0] cmp_sync;
  assign cmp_raw = temp_sense_cmp_i;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      csl_sync3 u_sync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .async_i(cmp_raw[gi]),
        .sync_o(cmp_sync[gi])
      );
    end
  endgenerate
  assign thm_s = cmp_sync;

  // =====================================================================
  // command decode
  assign v_cmd = cmd_i.valid && (cmd_i.code == csl_pkg::CMD_VOLTAGE);
  assign i_cmd = cmd_i.valid && (cmd_i.code == csl_pkg::CMD_CURRENT);
  assign a_cmd = cmd_i.valid && (cmd_i.code == csl_pkg::CMD_ALARM);
  assign c_cmd = cmd_i.valid && (cmd_i.code == csl_pkg::CMD_CONFIG);
  assign por_req = c_cmd && cmd_i.data[csl_pkg::CFG_POR_BIT];
  // bit 13 stops charging but does not latch the block
  assign alarm_set = a_cmd && (cmd_i.data[csl_pkg::ALARM_OT_BIT] ||
                               cmd_i.data[csl_pkg::ALARM_TC_BIT] ||
                               cmd_i.data[csl_pkg::ALARM_OC_BIT]);
  // pack removal also puts the timer back to its reset state
  assign restart = v_cmd || i_cmd || thm_s.open;
  assign new_code = cmd_i.data[csl_pkg::VCODE_MSB:csl_pkg::VCODE_LSB];
  assign raw_mv = {new_code, 4'h0};

  // =====================================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    expire = 1'b0;

    // level flags, each on its own comparator
    st_nxt.open = thm_s.open;
    st_nxt.cold = thm_s.cold;
    st_nxt.shorted = thm_s.shorted;

    // safety timer on a 1 ms enable tick
    if (restart) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tmo_cnt = '0;
      st_nxt.tmo_done = 1'b0;
    end else if (!st_r.tmo_done) begin
      if (st_r.tick_cnt == TICK_LAST) begin
        st_nxt.tick_cnt = '0;
        if (st_r.tmo_cnt == TMO_LAST) begin
          st_nxt.tmo_done = 1'b1;
          expire = 1'b1;
        end else begin
          st_nxt.tmo_cnt = st_r.tmo_cnt + 1'b1;
        end
      end else begin
        st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
      end
    end

    // voltage setpoint with floor and ceiling
    if (v_cmd) begin
      st_nxt.vcode = new_code;
      st_nxt.vset_valid = 1'b1;
      if (raw_mv < csl_pkg::VMIN_MV) begin
        st_nxt.vset_mv = csl_pkg::VMIN_MV;
      end else if (raw_mv > csl_pkg::VMAX_MV) begin
        st_nxt.vset_mv = csl_pkg::VMAX_MV;
      end else begin
        st_nxt.vset_mv = raw_mv;
      end
    end

    if (a_cmd) begin
      st_nxt.alarm_stop = |cmd_i.data[csl_pkg::ALARM_STOP_MSB:csl_pkg::ALARM_STOP_LSB];
    end
    if (c_cmd) begin
      st_nxt.hot_stop_en = cmd_i.data[csl_pkg::CFG_HOT_STOP_BIT];
    end

    // pack removed: back to the power-on setpoints
    if (thm_s.open) begin
      st_nxt.vset_valid = 1'b0;
      st_nxt.vcode = '0;
      st_nxt.vset_mv = csl_pkg::VMIN_MV;
      st_nxt.alarm_stop = 1'b0;
      st_nxt.hot_stop_en = csl_pkg::CFG_HOT_STOP_RST;
    end

    // alarm block: clears first, sets afterwards so a set wins
    if (v_cmd) begin
      st_nxt.seen_v = 1'b1;
    end
    if (i_cmd) begin
      st_nxt.seen_i = 1'b1;
    end
    if (st_nxt.seen_v && st_nxt.seen_i) begin
      st_nxt.alarm_block = 1'b0;
      st_nxt.seen_v = 1'b0;
      st_nxt.seen_i = 1'b0;
    end
    if (por_req || thm_s.open) begin
      st_nxt.alarm_block = 1'b0;
    end
    if (expire || alarm_set) begin
      st_nxt.alarm_block = 1'b1;
      st_nxt.seen_v = 1'b0;
      st_nxt.seen_i = 1'b0;
    end

    // hot latch: set wins over removal or reset request
    if (por_req || thm_s.open) begin
      st_nxt.hot = 1'b0;
    end
    if (thm_s.hot) begin
      st_nxt.hot = 1'b1;
    end

    // cold deliberately absent from the enable term
    st_nxt.chg_en = st_nxt.vset_valid && !st_nxt.open && !st_nxt.alarm_block &&
                    !st_nxt.alarm_stop && !st_nxt.tmo_done &&
                    !(st_nxt.hot && st_nxt.hot_stop_en && !st_nxt.shorted);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
      st_r.vset_mv <= csl_pkg::VMIN_MV;
      st_r.hot_stop_en <= csl_pkg::CFG_HOT_STOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign setpoint_mv_o = st_r.vset_mv;
  assign voltage_code_bits_o = st_r.vcode;
  assign charge_enable_o = st_r.chg_en;
  assign timer_expired_o = st_r.tmo_done;
  always_comb begin
    status_o.battery_present = !st_r.open;
    status_o.alarm_block = st_r.alarm_block;
    status_o.shorted = st_r.shorted;
    status_o.hot = st_r.hot;
    status_o.cold = st_r.cold;
    status_o.open = st_r.open;
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_v_scale;
    v_cmd && !thm_s.open && (raw_mv >= csl_pkg::VMIN_MV) && (raw_mv <= csl_pkg::VMAX_MV)
      |=> setpoint_mv_o == {$past(cmd_i.data[14:4]), 4'h0};
  endproperty
  a_v_scale: assert property (p_v_scale) else $error("setpoint not code times 16");

  property p_v_ignore;
    v_cmd && !thm_s.open |=> voltage_code_bits_o == $past(cmd_i.data[14:4]);
  endproperty
  a_v_ignore: assert property (p_v_ignore) else $error("code bits not from bits 4..14");

  property p_v_floor;
    setpoint_mv_o >= csl_pkg::VMIN_MV;
  endproperty
  a_v_floor: assert property (p_v_floor) else $error("setpoint below floor");

  property p_v_ceil;
    v_cmd && !thm_s.open && (raw_mv > csl_pkg::VMAX_MV) |=> setpoint_mv_o == csl_pkg::VMAX_MV;
  endproperty
  a_v_ceil: assert property (p_v_ceil) else $error("setpoint above ceiling not capped");

  property p_expire_stop;
    expire |=> !charge_enable_o && status_o.alarm_block && timer_expired_o;
  endproperty
  a_expire_stop: assert property (p_expire_stop) else $error("timeout did not stop charge");

  property p_restart;
    (v_cmd || i_cmd) |=> (st_r.tmo_cnt == '0) && (st_r.tick_cnt == '0) && !timer_expired_o;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");

  property p_alarm_stop;
    a_cmd && (cmd_i.data[15:12] != 4'h0) |=> !charge_enable_o;
  endproperty
  a_alarm_stop: assert property (p_alarm_stop) else $error("alarm did not stop charge");

  property p_open_por;
    thm_s.open && !thm_s.hot |=> !status_o.battery_present && !charge_enable_o && !status_o.hot;
  endproperty
  a_open_por: assert property (p_open_por) else $error("open sensor did not reset");

  property p_hot_hold;
    status_o.hot && !thm_s.open && !por_req |=> status_o.hot;
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("hot flag dropped");

  property p_hot_stop;
    status_o.hot && st_r.hot_stop_en && !status_o.shorted |-> !charge_enable_o;
  endproperty
  a_hot_stop: assert property (p_hot_stop) else $error("charging while hot");

  property p_pair_clear;
    v_cmd ##1 (i_cmd && !alarm_set && !expire) |=> !status_o.alarm_block;
  endproperty
  a_pair_clear: assert property (p_pair_clear) else $error("pair did not clear block");

  c_expire: cover property (expire);
  c_hot_short: cover property (status_o.hot && status_o.shorted);
  c_charge: cover property (charge_enable_o ##1 v_cmd ##1 charge_enable_o);
  c_block_clear: cover property (status_o.alarm_block ##[1:20] !status_o.alarm_block);

endmodule // csl_setpoint_safety

`default_nettype wire

// ### testbench/csl_host_model.sv
// command-issuing host model for the charger setpoint and safety logic
`timescale 1ns/100ps
`default_nettype none

module csl_host_model (
  input wire logic ref_clk_i,
  output var csl_pkg::csl_cmd_s cmd_o
);
  initial begin
    cmd_o = '0;
  end

  // ===================================================================
  // one-cycle strobe per command, launched just after an edge
  task automatic send(input logic [7:0] code, input logic [15:0] data);
    @(posedge ref_clk_i);
    #1;
    cmd_o = {1'b1, code, data};
    @(posedge ref_clk_i);
    #1;
    cmd_o.valid = 1'b0;
    // stale data is scrambled so nothing can lean on it
    cmd_o.data = ~data;
  endtask

  // ===================================================================
  // idle time; a live host keeps refreshing the safety timer
  task automatic pause(input int n, input bit alive);
    for (int i = 1; i <= n; i++) begin
      if (alive && (i % 5 == 0)) begin
        send(csl_pkg::CMD_CURRENT, 16'h0000);
      end else begin
        @(posedge ref_clk_i);
      end
    end
    // step off the edge so callers never sample outputs as they launch
    #1;
  endtask
endmodule // csl_host_model

`default_nettype wire

// ### testbench/charger_setpoint_and_safety_logic_test.sv
// self-checking testbench for the charger setpoint and safety logic
`timescale 1ns/100ps
`default_nettype none

module charger_setpoint_and_safety_logic_test;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  csl_pkg::csl_cmd_s cmd;
  csl_pkg::csl_thm_s temp_sense_input = '0;
  logic [14:0] mv;
  logic [10:0] code;
  logic en;
  logic tmo;
  csl_pkg::csl_status_s st;
  int mismatches = 0;
  int checked = 0;
  logic [15:0] vd [6] = '{16'h10a0, 16'h80af, 16'h0000, 16'h4000, 16'h7ff0, 16'h4b0f};
  logic [15:0] vm [6] = '{16'h10a0, 16'h0400, 16'h0400, 16'h4000, 16'h4b00, 16'h4b00};

  always #20 ref_clk_i = ~ref_clk_i;

  csl_host_model host (.ref_clk_i(ref_clk_i), .cmd_o(cmd));

  // short timer: expiry 20 cycles after the last refresh
  csl_setpoint_safety #(.TICK_CYCLES(4), .TIMEOUT_TICKS(5)) dut (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cmd_i(cmd),
    .temp_sense_cmp_i(temp_sense_input),
    .setpoint_mv_o(mv),
    .voltage_code_bits_o(code),
    .charge_enable_o(en),
    .timer_expired_o(tmo),
    .status_o(st)
  );

  // ===================================================================
  // compare, closing and comparator-drive tasks
  task automatic cmp_word(input string what, input logic [15:0] expv, input logic [15:0] got);
    checked++;
    if (got !== expv) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic expv, input logic got);
    checked++;
    if (got !== expv) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", what, expv, got);
    end
  endtask

  task automatic cmp_st(input logic [5:0] expv);
    cmp_word("status", {10'h000, expv}, {10'h000, st});
  endtask

  task automatic finish_test;
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic comparators(input logic [3:0] v);
    @(posedge ref_clk_i);
    #1;
    temp_sense_input = v;
    host.pause(9, 1'b1);
  endtask

  // ===================================================================
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #(40 * 4000);
    mismatches++;
    finish_test();
  end

  // ===================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    cmp_word("setpoint", 16'h0400, {1'b0, mv});
    cmp_bit("enable", 1'b0, en);
    cmp_st(6'h20);
    for (int i = 0; i < 6; i++) begin
      host.send(csl_pkg::CMD_VOLTAGE, vd[i]);
      cmp_word("setpoint", vm[i], {1'b0, mv});
      cmp_word("code", {5'h00, vd[i][14:4]}, {5'h00, code});
    end
    host.send(csl_pkg::CMD_VOLTAGE, 16'h10a0);
    cmp_bit("enable", 1'b1, en);
    for (int b = 12; b < 16; b++) begin
      host.send(csl_pkg::CMD_ALARM, 16'h0fff | (16'h0001 << b));
      cmp_bit("enable", 1'b0, en);
      cmp_bit("alarm block", (b != 13), st.alarm_block);
      host.send(csl_pkg::CMD_ALARM, 16'h0fff);
      cmp_bit("enable", (b == 13), en);
      host.send(csl_pkg::CMD_VOLTAGE, 16'h10a0);
      host.send(csl_pkg::CMD_CURRENT, 16'h0100);
      cmp_bit("enable", 1'b1, en);
      cmp_st(6'h20);
    end
    host.pause(60, 1'b1);
    cmp_bit("expired", 1'b0, tmo);
    cmp_bit("enable", 1'b1, en);
    host.pause(12, 1'b0);
    cmp_bit("expired", 1'b0, tmo);
    host.pause(14, 1'b0);
    cmp_bit("expired", 1'b1, tmo);
    cmp_bit("enable", 1'b0, en);
    cmp_st(6'h30);
    host.send(csl_pkg::CMD_VOLTAGE, 16'h10a0);
    host.send(csl_pkg::CMD_CURRENT, 16'h0100);
    cmp_bit("expired", 1'b0, tmo);
    cmp_bit("enable", 1'b1, en);
    comparators(4'h4);
    cmp_st(6'h22);
    cmp_bit("enable", 1'b1, en);
    comparators(4'h2);
    cmp_st(6'h24);
    cmp_bit("enable", 1'b0, en);
    comparators(4'h0);
    cmp_st(6'h24);
    comparators(4'h1);
    cmp_st(6'h2c);
    cmp_bit("enable", 1'b1, en);
    comparators(4'h0);
    cmp_bit("enable", 1'b0, en);
    host.send(csl_pkg::CMD_CONFIG, 16'h0000);
    cmp_bit("enable", 1'b1, en);
    host.send(csl_pkg::CMD_ALARM, 16'h8000);
    host.send(csl_pkg::CMD_ALARM, 16'h0000);
    cmp_st(6'h34);
    host.send(csl_pkg::CMD_CONFIG, 16'h0008);
    cmp_st(6'h20);
    host.send(csl_pkg::CMD_VOLTAGE, 16'h10a0);
    host.send(csl_pkg::CMD_ALARM, 16'h4000);
    comparators(4'h2);
    comparators(4'h8);
    cmp_st(6'h01);
    cmp_word("setpoint", 16'h0400, {1'b0, mv});
    cmp_bit("enable", 1'b0, en);
    comparators(4'h0);
    cmp_st(6'h20);
    finish_test();
  end
endmodule // charger_setpoint_and_safety_logic_test

`default_nettype wire
